// ==== common/unvm_cfg.svh ====
// Constants of the user nonvolatile bulk access block: command codes, key bytes and timing.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef UNVM_CFG_SVH
`define UNVM_CFG_SVH

`define UNVM_CMD_STORE 8'h15
`define UNVM_CMD_RESTORE 8'h16
`define UNVM_CMD_ACCESS_KEY 8'hBD
`define UNVM_CMD_BULK_CLEAR 8'hBE
`define UNVM_CMD_WORD_PORT 8'hBF

`define UNVM_KEY_FIRST 8'h2B
`define UNVM_KEY_PEC_OPT 8'hD4
`define UNVM_KEY_PEC_REQ 8'hD5
`define UNVM_CLEAR_CODE 8'h2B

`define UNVM_BYTE_RESET 8'h00
`define UNVM_WORD_RESET 16'h0000
`define UNVM_ERASED_WORD 16'hFFFF
// Arbitrary packing identifier value.
`define UNVM_PACK_ID 16'h0001

`define UNVM_CLK_MHZ 50
`define UNVM_PROG_TIME_NS 510000
`define UNVM_ERASE_TIME_US 400000
`define UNVM_PROG_CYC ((`UNVM_PROG_TIME_NS * `UNVM_CLK_MHZ + 999) / 1000)
`define UNVM_ERASE_CYC (`UNVM_ERASE_TIME_US * `UNVM_CLK_MHZ)

`endif

// ==== common/unvm_pkg.sv ====
// Types of the user nonvolatile bulk access block.
// Assumes nothing beyond a SystemVerilog compiler.
package unvm_pkg;

    typedef enum logic [3:0] {
        UNVM_IDLE,
        UNVM_RD_WAIT,
        UNVM_PROG,
        UNVM_ERASE,
        UNVM_STORE_RD,
        UNVM_STORE_WR,
        UNVM_STORE_PROG,
        UNVM_REST_RD,
        UNVM_REST_WR,
        UNVM_REST_NX
    } unvm_state_t;

    typedef enum logic [1:0] {
        UNVM_LOCKED,
        UNVM_HALF,
        UNVM_OPEN
    } unvm_key_t;

    typedef enum logic [1:0] {
        UNVM_DIR_NONE,
        UNVM_DIR_RD,
        UNVM_DIR_WR
    } unvm_dir_t;

endpackage

// ==== common/unvm_mem_if.sv ====
// Port between the access controller and the user word store.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface unvm_mem_if #(
    parameter int AW = 6
);
    logic [AW-1:0] addr;
    logic [15:0] wdata;
    logic we;
    logic [15:0] rdata;

    modport ctl (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface

// ==== verilog/unvm_eeprom.sv ====
// User word store with registered read data.
// Assumes one access per clock from the controller.
`timescale 1ns/10ps
module unvm_eeprom
    import unvm_pkg::*;
#(
    parameter int AW = 6
) (
    input wire logic clk,
    unvm_mem_if.mem port
);
    logic [15:0] cells [0:(1<<AW)-1];
    logic [15:0] rdata;

    always_ff @(posedge clk) begin
        if (port.we) begin
            cells[port.addr] <= port.wdata;
        end
        rdata <= cells[port.addr];
    end

    assign port.rdata = rdata;
endmodule

// ==== verilog/unvm_top.sv ====
// User nonvolatile bulk access controller: save, reload and word-wise cloning of the user store.
// Assumes a bus front end on clk that delivers decoded commands and a config RAM with one-cycle reads.
//
// How it works
// RULE1: Store command copies config into store.
// RULE2: Reload command copies store into config.
// RULE3: Reload also after reset and pin toggle.
// RULE4: Busy reported during save or reload.
// RULE5: Monitoring suspended while reloading.
// RULE6: Key command opens bulk access.
// RULE7: Valid clear code erases and arms writing.
// RULE8: Word port moves one word per access.
// RULE9: Word transfers never touch config RAM.
// RULE10: Host uses only byte and word transfers.
// RULE11: Unlock zeroes pointer; each word advances it.
// RULE12: Unlock key selects optional or required PEC.
// RULE13: Busy reported during bulk store access.
// RULE14: Busy clears ready flag, refuses commands.
// RULE15: Key 2B then D4 or D5, else lock.
// RULE16: Clear code 2B erases, else lock; reads last.
// RULE17: First reads give id, then size, then data.
// RULE18: Locked state never lets word port or clear alter or expose store.
`timescale 1ns/10ps
`include "unvm_cfg.svh"
module unvm_top
    import unvm_pkg::*;
#(
    parameter int USER_WORDS = 64,
    parameter int PROG_CYCLES = `UNVM_PROG_CYC,
    parameter int ERASE_CYCLES = `UNVM_ERASE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_reset_n,
    input wire logic txn_valid,
    input wire logic txn_write,
    input wire logic [7:0] txn_code,
    input wire logic [15:0] txn_wdata,
    input wire logic txn_pec_ok,
    output logic txn_done,
    output logic txn_nack,
    output logic [15:0] txn_rdata,
    output logic not_busy,
    output logic monitor_suspend,
    output logic [$clog2(USER_WORDS)-1:0] cfg_addr,
    output logic [15:0] cfg_wdata,
    output logic cfg_we,
    input wire logic [15:0] cfg_rdata
);
    localparam int AW = $clog2(USER_WORDS);
    localparam int PW = AW + 2;
    localparam int TW = 25;

    unvm_mem_if #(.AW(AW)) mem_port ();

    unvm_eeprom #(.AW(AW)) u_store (
        .clk(clk),
        .port(mem_port.mem)
    );

    unvm_state_t state, next_state;
    unvm_key_t key_st, next_key_st;
    unvm_dir_t dir, next_dir;
    logic [TW-1:0] timer, next_timer;
    logic [PW-1:0] idx, next_idx;
    logic pec_req, next_pec_req;
    logic erased, next_erased;
    logic [7:0] key_last, next_key_last;
    logic [7:0] clr_last, next_clr_last;
    logic done, next_done;
    logic nack, next_nack;
    logic [15:0] rdata, next_rdata;
    logic boot, next_boot;
    logic pin_req, next_pin_req;
    logic [15:0] wdata_r, next_wdata_r;
    logic we_r, next_we_r;
    logic pin_s1, pin_s2, pin_s3;
    logic [AW-1:0] m_addr;
    logic [15:0] m_wd;
    logic m_we;
    logic pin_rise;
    logic pec_bad;

    assign pin_rise = pin_s2 && !pin_s3;
    assign pec_bad = pec_req && !txn_pec_ok && (txn_code >= `UNVM_CMD_ACCESS_KEY);

    always_comb begin
        next_state = state;
        next_key_st = key_st;
        next_dir = dir;
        next_timer = timer;
        next_idx = idx;
        next_pec_req = pec_req;
        next_erased = erased;
        next_key_last = key_last;
        next_clr_last = clr_last;
        next_done = 1'b0;
        next_nack = 1'b0;
        next_rdata = rdata;
        next_boot = boot;
        next_pin_req = pin_req || pin_rise;
        next_wdata_r = wdata_r;
        next_we_r = 1'b0;
        m_addr = idx[AW-1:0];
        m_wd = `UNVM_ERASED_WORD;
        m_we = 1'b0;
        case (state)
            UNVM_IDLE: begin
                if (boot || pin_req) begin
                    next_boot = 1'b0; // RULE3
                    next_pin_req = pin_rise;
                    next_idx = '0;
                    next_state = UNVM_REST_RD; // RULE3
                    if (txn_valid) begin
                        next_done = 1'b1;
                        next_nack = 1'b1; // RULE14
                    end
                end else if (txn_valid) begin
                    next_done = 1'b1;
                    next_rdata = `UNVM_WORD_RESET;
                    if (pec_bad) begin
                        next_nack = 1'b1; // RULE12
                    end else if (txn_code == `UNVM_CMD_STORE && txn_write) begin
                        next_idx = '0;
                        next_state = UNVM_STORE_RD; // RULE1
                    end else if (txn_code == `UNVM_CMD_RESTORE && txn_write) begin
                        next_idx = '0;
                        next_state = UNVM_REST_RD; // RULE2
                    end else if (txn_code == `UNVM_CMD_ACCESS_KEY && txn_write) begin
                        next_key_last = txn_wdata[7:0];
                        next_dir = UNVM_DIR_NONE;
                        next_erased = 1'b0;
                        if (txn_wdata[7:0] == `UNVM_KEY_FIRST) begin
                            next_key_st = UNVM_HALF; // RULE15
                        end else if (key_st == UNVM_HALF && (txn_wdata[7:0] == `UNVM_KEY_PEC_OPT
                                || txn_wdata[7:0] == `UNVM_KEY_PEC_REQ)) begin
                            next_key_st = UNVM_OPEN; // RULE6
                            next_pec_req = (txn_wdata[7:0] == `UNVM_KEY_PEC_REQ); // RULE12
                            next_idx = '0; // RULE11
                        end else begin
                            next_key_st = UNVM_LOCKED; // RULE15
                        end
                    end else if (txn_code == `UNVM_CMD_ACCESS_KEY) begin
                        next_rdata = {8'h00, (key_st == UNVM_LOCKED) ? `UNVM_BYTE_RESET : key_last};
                    end else if (txn_code == `UNVM_CMD_BULK_CLEAR && txn_write) begin
                        next_clr_last = txn_wdata[7:0]; // RULE16
                        if (key_st == UNVM_OPEN && txn_wdata[7:0] == `UNVM_CLEAR_CODE) begin
                            next_erased = 1'b1; // RULE7
                            next_idx = '0;
                            next_timer = TW'(ERASE_CYCLES - 1);
                            next_state = UNVM_ERASE; // RULE16
                        end else begin
                            next_key_st = UNVM_LOCKED; // RULE18
                            next_erased = 1'b0;
                        end
                    end else if (txn_code == `UNVM_CMD_BULK_CLEAR) begin
                        next_rdata = {8'h00, clr_last}; // RULE16
                    end else if (txn_code == `UNVM_CMD_WORD_PORT && !txn_write) begin
                        if (key_st == UNVM_OPEN && dir != UNVM_DIR_WR && idx <= PW'(USER_WORDS + 1)) begin
                            next_dir = UNVM_DIR_RD;
                            next_idx = idx + 1'b1; // RULE11
                            if (idx == '0) begin
                                next_rdata = `UNVM_PACK_ID; // RULE17
                            end else if (idx == PW'(1)) begin
                                next_rdata = 16'(USER_WORDS); // RULE17
                            end else begin
                                m_addr = AW'(idx - PW'(2)); // RULE8
                                next_done = 1'b0;
                                next_rdata = rdata;
                                next_state = UNVM_RD_WAIT; // RULE17
                            end
                        end else begin
                            next_key_st = UNVM_LOCKED; // RULE18
                            next_erased = 1'b0;
                        end
                    end else if (txn_code == `UNVM_CMD_WORD_PORT) begin
                        if (key_st == UNVM_OPEN && erased && dir != UNVM_DIR_RD && idx < PW'(USER_WORDS)) begin
                            next_dir = UNVM_DIR_WR;
                            m_addr = idx[AW-1:0];
                            m_wd = txn_wdata;
                            m_we = 1'b1; // RULE9
                            next_idx = idx + 1'b1; // RULE11
                            next_timer = TW'(PROG_CYCLES - 1);
                            next_state = UNVM_PROG; // RULE13
                        end else begin
                            next_key_st = UNVM_LOCKED; // RULE18
                            next_erased = 1'b0;
                        end
                    end else begin
                        next_nack = 1'b1;
                    end
                end
            end
            UNVM_RD_WAIT: begin
                next_rdata = mem_port.rdata; // RULE8
                next_done = 1'b1;
                next_state = UNVM_IDLE;
            end
            UNVM_PROG: begin
                next_timer = timer - 1'b1;
                if (timer == '0) begin
                    next_state = UNVM_IDLE;
                end
            end
            UNVM_ERASE: begin
                next_timer = timer - 1'b1;
                if (idx < PW'(USER_WORDS)) begin
                    m_we = 1'b1;
                    next_idx = idx + 1'b1;
                end
                if (timer == '0) begin
                    next_idx = '0;
                    next_state = UNVM_IDLE;
                end
            end
            UNVM_STORE_RD: begin
                next_state = UNVM_STORE_WR;
            end
            UNVM_STORE_WR: begin
                m_wd = cfg_rdata;
                m_we = 1'b1; // RULE1
                next_timer = TW'(PROG_CYCLES - 1);
                next_state = UNVM_STORE_PROG;
            end
            UNVM_STORE_PROG: begin
                next_timer = timer - 1'b1;
                if (timer == '0) begin
                    next_idx = idx + 1'b1;
                    next_state = (idx == PW'(USER_WORDS - 1)) ? UNVM_IDLE : UNVM_STORE_RD;
                end
            end
            UNVM_REST_RD: begin
                next_state = UNVM_REST_WR;
            end
            UNVM_REST_WR: begin
                next_wdata_r = mem_port.rdata;
                next_we_r = 1'b1; // RULE2
                next_state = UNVM_REST_NX;
            end
            UNVM_REST_NX: begin
                next_idx = idx + 1'b1;
                next_state = (idx == PW'(USER_WORDS - 1)) ? UNVM_IDLE : UNVM_REST_RD;
            end
            default: begin
                next_state = UNVM_IDLE;
            end
        endcase
        if (state != UNVM_IDLE && txn_valid) begin
            next_done = 1'b1;
            next_nack = 1'b1; // RULE14
        end
    end

    always_ff @(posedge clk) begin
        pin_s1 <= pin_reset_n;
        pin_s2 <= pin_s1 || !rst_n;
        pin_s3 <= pin_s2 || !rst_n;
        if (!rst_n) begin
            state <= UNVM_IDLE;
            key_st <= UNVM_LOCKED;
            dir <= UNVM_DIR_NONE;
            timer <= '0;
            idx <= '0;
            pec_req <= 1'b0;
            erased <= 1'b0;
            key_last <= `UNVM_BYTE_RESET;
            clr_last <= `UNVM_BYTE_RESET;
            done <= 1'b0;
            nack <= 1'b0;
            rdata <= `UNVM_WORD_RESET;
            boot <= 1'b1;
            pin_req <= 1'b0;
            wdata_r <= `UNVM_WORD_RESET;
            we_r <= 1'b0;
        end else begin
            state <= next_state;
            key_st <= next_key_st;
            dir <= next_dir;
            timer <= next_timer;
            idx <= next_idx;
            pec_req <= next_pec_req;
            erased <= next_erased;
            key_last <= next_key_last;
            clr_last <= next_clr_last;
            done <= next_done;
            nack <= next_nack;
            rdata <= next_rdata;
            boot <= next_boot;
            pin_req <= next_pin_req;
            wdata_r <= next_wdata_r;
            we_r <= next_we_r;
        end
    end

    assign mem_port.addr = m_addr;
    assign mem_port.wdata = m_wd;
    assign mem_port.we = m_we;
    assign txn_done = done;
    assign txn_nack = nack;
    assign txn_rdata = rdata;
    assign not_busy = (state == UNVM_IDLE) && !boot && !pin_req; // RULE4 RULE13
    assign monitor_suspend = (state == UNVM_REST_RD) || (state == UNVM_REST_WR)
        || (state == UNVM_REST_NX) || boot; // RULE5
    assign cfg_addr = idx[AW-1:0];
    assign cfg_wdata = wdata_r;
    assign cfg_we = we_r;
endmodule

// ==== tb/unvm_cfg_ram.sv ====
// Config RAM model on the far side of the bulk access controller.
// Assumes address and write strobe change just after the rising edge of clk.
`timescale 1ns/10ps
module unvm_cfg_ram #(
    parameter int AW = 2
) (
    input wire logic clk,
    input wire logic [AW-1:0] cfg_addr,
    input wire logic [15:0] cfg_wdata,
    input wire logic cfg_we,
    output logic [15:0] cfg_rdata
);
    logic [15:0] mem [2**AW];
    int wr_cnt = 0;

    // Registered read, valid the cycle after the address; writes are counted.
    always @(posedge clk) begin
        cfg_rdata <= mem[cfg_addr];
        if (cfg_we) begin
            mem[cfg_addr] <= cfg_wdata;
            wr_cnt <= wr_cnt + 1;
        end
    end
endmodule

// ==== tb/unvm_top_checker.sv ====
// Port checker of the bulk access controller.
// Assumes it is bound into unvm_top and sees only its ports.
`timescale 1ns/10ps
module unvm_top_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_reset_n,
    input wire logic txn_valid,
    input wire logic txn_write,
    input wire logic [7:0] txn_code,
    input wire logic txn_done,
    input wire logic txn_nack,
    input wire logic [15:0] txn_rdata,
    input wire logic not_busy,
    input wire logic monitor_suspend,
    input wire logic cfg_we
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic cmd_store;
    logic cmd_reload;
    assign cmd_store = txn_valid && txn_write && txn_code == 8'h15 && not_busy;
    assign cmd_reload = txn_valid && txn_write && txn_code == 8'h16 && not_busy;

    busy_refuse_a: assert property (txn_valid && !not_busy |=> txn_done && txn_nack)
        else $error("Busy request not refused.");
    store_busy_a: assert property (cmd_store |=> txn_done && !txn_nack && !not_busy)
        else $error("Store not accepted as busy.");
    reload_busy_a: assert property (cmd_reload |=> monitor_suspend && !not_busy)
        else $error("Reload without suspended monitoring.");
    answer_time_a: assert property (txn_valid && not_busy |-> ##[1:2] txn_done)
        else $error("Request not answered in time.");
    cfg_quiet_a: assert property (cfg_we |-> $past(monitor_suspend))
        else $error("Config written outside a reload.");
    boot_reload_a: assert property ($rose(rst_n) |=> monitor_suspend && !not_busy)
        else $error("No reload after reset.");
    pin_reload_a: assert property ($rose(pin_reset_n) |-> ##[1:8] monitor_suspend)
        else $error("No reload after pin reset.");
    rdata_hold_a: assert property (!txn_done |-> $stable(txn_rdata))
        else $error("Read data changed without an answer.");

    cover property (cmd_reload);
    cover property (txn_done && txn_nack);
    cover property (txn_valid && !txn_write && txn_code == 8'hBF);
endmodule

bind unvm_top unvm_top_checker chk_i (.clk(clk), .rst_n(rst_n), .pin_reset_n(pin_reset_n),
    .txn_valid(txn_valid), .txn_write(txn_write), .txn_code(txn_code), .txn_done(txn_done),
    .txn_nack(txn_nack), .txn_rdata(txn_rdata), .not_busy(not_busy),
    .monitor_suspend(monitor_suspend), .cfg_we(cfg_we));

// ==== tb/user_nvm_bulk_access_test.sv ====
// Self-checking bench of the bulk access controller.
// Assumes the checker is bound and the config RAM model stands on the far side.
`timescale 1ns/10ps
`include "unvm_cfg.svh"
module user_nvm_bulk_access_test;
    localparam int UW = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin_reset_n = 1'b1;
    logic txn_valid = 1'b0;
    logic txn_write = 1'b0;
    logic [7:0] txn_code = 8'h00;
    logic [15:0] txn_wdata = 16'h0000;
    logic txn_pec_ok = 1'b1;
    logic txn_done, txn_nack, not_busy, monitor_suspend, cfg_we;
    logic [15:0] txn_rdata, cfg_wdata, cfg_rdata, q;
    logic [1:0] cfg_addr;
    logic nk;
    int fails = 0;
    int cmp_count = 0;

    initial begin
        forever #10 clk = ~clk;
    end

    unvm_top #(.USER_WORDS(UW), .PROG_CYCLES(4), .ERASE_CYCLES(80)) DUT (.clk(clk), .rst_n(rst_n),
        .pin_reset_n(pin_reset_n), .txn_valid(txn_valid), .txn_write(txn_write), .txn_code(txn_code),
        .txn_wdata(txn_wdata), .txn_pec_ok(txn_pec_ok), .txn_done(txn_done), .txn_nack(txn_nack),
        .txn_rdata(txn_rdata), .not_busy(not_busy), .monitor_suspend(monitor_suspend),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we), .cfg_rdata(cfg_rdata));
    unvm_cfg_ram #(.AW(2)) ram (.clk(clk), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_we(cfg_we), .cfg_rdata(cfg_rdata));

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus command; returns the answer in q and nk.
    task automatic txn(input logic w, input logic [7:0] c, input logic [15:0] d);
        int n;
        n = 0;
        txn_valid <= 1'b1;
        txn_write <= w;
        txn_code <= c;
        txn_wdata <= d;
        @(posedge clk);
        txn_valid <= 1'b0;
        #1;
        while (txn_done !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (txn_done !== 1'b1) begin
            fails++;
            wrap_up();
        end
        q = txn_rdata;
        nk = txn_nack;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e, input string nm);
        txn(1'b0, c, 16'h0000);
        chk(nm, e, q);
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
        txn(1'b1, c, d);
        chk("nack", 16'(e), 16'(nk));
    endtask

    // Expects the part busy on entry, then waits until it is ready.
    task automatic wait_ready();
        int n;
        n = 0;
        #1;
        chk("busy", 16'h0000, 16'(not_busy));
        while (not_busy !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (not_busy !== 1'b1) begin
            fails++;
            wrap_up();
        end
        @(posedge clk);
    endtask

    task automatic unlock(input logic [7:0] k);
        wr(8'hBD, 16'h002B, 1'b0);
        wr(8'hBD, 16'(k), 1'b0);
    endtask

    task automatic cfg_chk();
        for (int i = 0; i < UW; i++) begin
            chk("config word", 16'hC000 + 16'(i), ram.mem[i]);
        end
    endtask

    task automatic t_boot();
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("boot suspend", 16'h0001, 16'(monitor_suspend));
        @(posedge clk);
        wr(8'hBD, 16'h002B, 1'b1);
        wait_ready();
        rd(8'hBD, 16'h0000, "key locked");
    endtask

    task automatic t_store();
        for (int i = 0; i < UW; i++) begin
            ram.mem[i] = 16'h1000 + 16'(i);
        end
        wr(8'h15, 16'h0000, 1'b0);
        wait_ready();
    endtask

    task automatic t_read();
        unlock(8'hD4);
        txn_pec_ok <= 1'b0;
        rd(8'hBD, 16'h00D4, "key");
        txn_pec_ok <= 1'b1;
        rd(8'hBF, `UNVM_PACK_ID, "pack id");
        rd(8'hBF, 16'(UW), "word count");
        for (int i = 0; i < UW; i++) begin
            rd(8'hBF, 16'h1000 + 16'(i), "stored word");
        end
        rd(8'hBF, 16'h0000, "extra read");
        rd(8'hBD, 16'h0000, "key after read");
    endtask

    task automatic t_write();
        int c0;
        c0 = ram.wr_cnt;
        unlock(8'hD4);
        wr(8'hBE, 16'h002B, 1'b0);
        wait_ready();
        rd(8'hBE, 16'h002B, "clear byte");
        for (int i = 0; i < UW; i++) begin
            wr(8'hBF, 16'hC000 + 16'(i), 1'b0);
            wait_ready();
        end
        wr(8'hBF, 16'hC0DE, 1'b0);
        rd(8'hBD, 16'h0000, "key after write");
        chk("config writes", 16'(c0), 16'(ram.wr_cnt));
    endtask

    task automatic t_reload();
        wr(8'h16, 16'h0000, 1'b0);
        wait_ready();
        cfg_chk();
    endtask

    task automatic t_pec();
        unlock(8'hD5);
        txn_pec_ok <= 1'b0;
        txn(1'b0, 8'hBD, 16'h0000);
        chk("nack without pec", 16'h0001, 16'(nk));
        txn_pec_ok <= 1'b1;
        rd(8'hBD, 16'h00D5, "key pec");
        wr(8'hBE, 16'h0011, 1'b0);
        rd(8'hBD, 16'h0000, "key bad clear");
        unlock(8'h77);
        rd(8'hBD, 16'h0000, "key bad sequence");
    endtask

    task automatic t_pin();
        int n;
        n = 0;
        for (int i = 0; i < UW; i++) begin
            ram.mem[i] = 16'h0000;
        end
        pin_reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        pin_reset_n <= 1'b1;
        #1;
        while (monitor_suspend !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("pin suspend", 16'h0001, 16'(monitor_suspend));
        @(posedge clk);
        wait_ready();
        cfg_chk();
    endtask

    initial begin
        t_boot();
        t_store();
        t_read();
        t_write();
        t_reload();
        t_pec();
        t_pin();
        wrap_up();
    end
endmodule
